// ### common/pss_pkg.sv
package pss_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int SLOT_MS = 8;
	localparam int HOST_WIN_MS = 1;
	localparam int XCHG_WIN_MS = 5;
	localparam int STEP_US = 5;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int SLOT_CYC = SLOT_MS * CYC_PER_MS;
	localparam int STEP_CYC = STEP_US * CLK_MHZ;
	// ----------------------------------------
	// Memory sizes and reset values
	// ----------------------------------------
	localparam int HOST_BYTES = 256;
	localparam int MACH_BYTES = 128;
	localparam int TC_WORDS = 128;
	localparam int TC_AW = 7;
	localparam int HOST_AW = 8;
	localparam int MACH_AW = 7;
	localparam int WORD_W = 16;
	localparam logic [7:0] IMG_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// ----------------------------------------
	// Diagnostic image select
	// ----------------------------------------
	typedef enum logic [1:0] {
		PSS_IMG_HOST_IN = 2'b00,
		PSS_IMG_HOST_OUT = 2'b01,
		PSS_IMG_MACH_IN = 2'b10,
		PSS_IMG_MACH_OUT = 2'b11
	} pss_img_t;
	// ----------------------------------------
	// Scheduler phases
	// ----------------------------------------
	typedef enum logic [2:0] {
		PSS_PH_HOST = 3'b000,
		PSS_PH_L1 = 3'b001,
		PSS_PH_L2 = 3'b010,
		PSS_PH_IDLE = 3'b011,
		PSS_PH_XCHG = 3'b100
	} pss_phase_t;
endpackage : pss_pkg

// ### verilog/pss_scheduler.sv
`timescale 1ns/1ns
// Contract
// (R1) Whole level-one program runs once every 8 ms slot.
// (R2) Level two split into n partitions; one partition per slot after level one.
// (R3) After last partition, level two restarts at first; period n slots.
// (R4) First millisecond of each slot is the host access window.
// (R5) Fifth millisecond: fetch host and machine inputs, deliver outputs.
// (R6) Rung evaluation suspended during host and exchange windows, else runs; code idles in PSS_PH_IDLE from partition end to slot end.
// (R7) Rungs evaluated one at a time in stored order.
// (R8) After last rung, evaluation wraps to the first rung.
// (R9) Host-input image refreshed every 8 ms; level one reads it directly.
// (R10) Machine inputs sampled every 8 ms into image; level one reads it directly.
// (R11) Both input images copied into level-two latch only at level-two cycle start.
// (R12) Level-two latch constant during a level-two cycle; level two reads only it.
// (R13) Computed host outputs copied to host output memory every 8 ms.
// (R14) Machine output memory driven onto machine outputs every 8 ms.
// (R15) Four image memories readable for diagnostics by rung byte address.
// (R16) Host input and output areas span byte addresses 0 to 255.
// (R17) 128 word timers with 128 word presets.
// (R18) 128 word counters with 128 word presets.
// (R19) Each basic rung step budgeted at 5 us.
// (R20) Level-two input view may trail level one by one level-two cycle.
// (R21) Level one finishes before partition starts; n is at least one.
module pss_scheduler #(
	parameter int SLOT_CYCLES = pss_pkg::SLOT_CYC,
	parameter int MS_CYCLES = pss_pkg::CYC_PER_MS,
	parameter int STEP_CYCLES = pss_pkg::STEP_CYC,
	parameter int L1_RUNGS = 64,
	parameter int L2_RUNGS = 256,
	parameter int RUNG_AW = 8,
	parameter int PART_AW = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [PART_AW-1:0] l2_parts,
	// Host side
	output logic host_win,
	input wire logic host_we,
	input wire logic [pss_pkg::HOST_AW-1:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	// Machine side
	input wire logic [8*pss_pkg::MACH_BYTES-1:0] mach_in,
	output logic [8*pss_pkg::MACH_BYTES-1:0] mach_out,
	output logic xchg_win,
	// Rung engine
	output logic rung_go,
	output logic rung_lvl2,
	output logic [RUNG_AW-1:0] rung_idx,
	input wire logic rung_done,
	output logic l2_cycle_start,
	// Rung image access
	input wire logic [pss_pkg::HOST_AW-1:0] rd_addr,
	output logic [7:0] rd_host_in,
	output logic [7:0] rd_mach_in,
	input wire logic res_we,
	input wire logic res_to_mach,
	input wire logic [pss_pkg::HOST_AW-1:0] res_addr,
	input wire logic [7:0] res_data,
	// Timer and counter words
	input wire logic tc_we,
	input wire logic [1:0] tc_sel,
	input wire logic [pss_pkg::TC_AW-1:0] tc_addr,
	input wire logic [pss_pkg::WORD_W-1:0] tc_wdata,
	output logic [pss_pkg::WORD_W-1:0] tc_rdata,
	// Diagnostics
	input wire logic [1:0] diag_sel,
	input wire logic [pss_pkg::HOST_AW-1:0] diag_addr,
	output logic [7:0] diag_data,
	output logic [PART_AW-1:0] l2_part
);
	import pss_pkg::*;

	// ----------------------------------------
	// Memories
	// ----------------------------------------
	logic [7:0] host_mail_reg [HOST_BYTES];
	logic [7:0] host_in_img_reg [HOST_BYTES];
	logic [7:0] host_res_reg [HOST_BYTES];
	logic [7:0] host_out_img_reg [HOST_BYTES];
	logic [7:0] mach_in_img_reg [MACH_BYTES];
	logic [7:0] mach_res_reg [MACH_BYTES];
	logic [7:0] mach_out_img_reg [MACH_BYTES];
	logic [7:0] l2_host_latch_reg [HOST_BYTES];
	logic [7:0] l2_mach_latch_reg [MACH_BYTES];
	logic [WORD_W-1:0] tc_mem_reg [4][TC_WORDS];
	logic [7:0] mach_sync1_reg [MACH_BYTES];
	logic [7:0] mach_sync2_reg [MACH_BYTES];

	// ----------------------------------------
	// Slot timing
	// ----------------------------------------
	logic [31:0] slot_cnt_reg;
	logic [31:0] step_cnt_reg;
	logic slot_start;
	logic xchg_pulse;
	logic in_host;
	logic in_xchg;
	pss_phase_t phase_reg;
	logic [RUNG_AW-1:0] rung_reg;
	logic [PART_AW-1:0] part_reg;
	logic [PART_AW-1:0] nparts;
	logic [RUNG_AW:0] part_len;
	logic [RUNG_AW:0] part_end;
	int part_top;
	logic l2_restart;

	function automatic logic [7:0] rd_mach(input logic [7:0] m [MACH_BYTES], input logic [HOST_AW-1:0] a);
		rd_mach = a[HOST_AW-1] ? IMG_RST : m[a[MACH_AW-1:0]];
	endfunction : rd_mach

	assign slot_start = (slot_cnt_reg == 32'(SLOT_CYCLES - 1));
	assign in_host = (slot_cnt_reg < 32'(HOST_WIN_MS * MS_CYCLES)); // R4
	assign in_xchg = (slot_cnt_reg >= 32'((XCHG_WIN_MS - 1) * MS_CYCLES))
		&& (slot_cnt_reg < 32'(XCHG_WIN_MS * MS_CYCLES)); // R5
	assign xchg_pulse = (slot_cnt_reg == 32'((XCHG_WIN_MS - 1) * MS_CYCLES));
	assign nparts = (l2_parts == '0) ? PART_AW'(1) : l2_parts; // R21
	// One bit wider than a rung index, so a full program in one partition still fits
	always_comb begin
		part_top = (int'(part_reg) + 1) * int'((L2_RUNGS + int'(nparts) - 1) / int'(nparts));
		part_len = (RUNG_AW+1)'((L2_RUNGS + int'(nparts) - 1) / int'(nparts)); // R2
		if (part_top > L2_RUNGS) begin
			part_end = (RUNG_AW+1)'(L2_RUNGS);
		end else begin
			part_end = (RUNG_AW+1)'(part_top);
		end
	end
	// A count lowered mid-run wraps at the next slot instead of running to all ones
	assign l2_restart = slot_start && (part_reg >= nparts - PART_AW'(1));

	always_ff @(posedge core_clk) begin
		if (!rstn || slot_start) begin
			slot_cnt_reg <= '0;
		end else begin
			slot_cnt_reg <= slot_cnt_reg + 32'd1;
		end
	end

	// ----------------------------------------
	// Rung sequencer
	// ----------------------------------------
	// Step pacing keeps throughput at the budget; engine done also advances
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			phase_reg <= PSS_PH_HOST;
			rung_reg <= '0;
			step_cnt_reg <= '0;
		end else if (slot_start) begin
			phase_reg <= PSS_PH_HOST;
			rung_reg <= '0; // R1
			step_cnt_reg <= '0;
		end else if (in_host || in_xchg) begin
			if (phase_reg == PSS_PH_HOST) begin
				phase_reg <= PSS_PH_L1;
			end
			step_cnt_reg <= '0; // R6
		end else begin
			case (phase_reg)
				PSS_PH_HOST, PSS_PH_L1: begin
					phase_reg <= PSS_PH_L1;
					if (rung_done || step_cnt_reg == 32'(STEP_CYCLES - 1)) begin // R19
						step_cnt_reg <= '0;
						if (rung_reg == RUNG_AW'(L1_RUNGS - 1)) begin
							phase_reg <= PSS_PH_L2; // R21
							rung_reg <= RUNG_AW'(int'(part_reg) * int'(part_len));
						end else begin
							rung_reg <= rung_reg + RUNG_AW'(1); // R7
						end
					end else begin
						step_cnt_reg <= step_cnt_reg + 32'd1;
					end
				end
				PSS_PH_L2: begin
					if (rung_done || step_cnt_reg == 32'(STEP_CYCLES - 1)) begin
						step_cnt_reg <= '0;
						if ({1'b0, rung_reg} + (RUNG_AW+1)'(1) >= part_end) begin
							phase_reg <= PSS_PH_IDLE; // R2
						end else begin
							rung_reg <= rung_reg + RUNG_AW'(1); // R7
						end
					end else begin
						step_cnt_reg <= step_cnt_reg + 32'd1;
					end
				end
				default: begin
					phase_reg <= PSS_PH_IDLE;
				end
			endcase
		end
	end

	// Wraps to partition zero, which restarts the scan from rung zero
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			part_reg <= '0;
		end else if (l2_restart) begin
			part_reg <= '0; // R3 R8
		end else if (slot_start) begin
			part_reg <= part_reg + PART_AW'(1);
		end
	end

	assign host_win = in_host;
	assign xchg_win = in_xchg;
	assign rung_go = !in_host && !in_xchg && (phase_reg == PSS_PH_L1 || phase_reg == PSS_PH_L2); // R6
	assign rung_lvl2 = (phase_reg == PSS_PH_L2);
	assign rung_idx = rung_reg;
	assign l2_part = part_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			l2_cycle_start <= 1'b1;
		end else begin
			l2_cycle_start <= l2_restart;
		end
	end

	// ----------------------------------------
	// Host mailbox and images
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (in_host && host_we) begin
			host_mail_reg[host_addr] <= host_wdata; // R4 R16
		end
	end

	always_ff @(posedge core_clk) begin
		host_rdata <= host_out_img_reg[host_addr]; // R4
	end

	// Images copied whole on the exchange edge so a scan sees one snapshot
	generate
		for (genvar i = 0; i < HOST_BYTES; i++) begin : g_host
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					host_in_img_reg[i] <= IMG_RST;
					host_out_img_reg[i] <= IMG_RST;
					host_res_reg[i] <= IMG_RST;
					l2_host_latch_reg[i] <= IMG_RST;
				end else begin
					if (xchg_pulse) begin
						host_in_img_reg[i] <= host_mail_reg[i]; // R9
						host_out_img_reg[i] <= host_res_reg[i]; // R13
					end
					if (res_we && !res_to_mach && res_addr == HOST_AW'(i)) begin
						host_res_reg[i] <= res_data;
					end
					if (l2_restart || l2_cycle_start) begin
						l2_host_latch_reg[i] <= host_in_img_reg[i]; // R11 R12 R20
					end
				end
			end
		end
		for (genvar j = 0; j < MACH_BYTES; j++) begin : g_mach
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					mach_sync1_reg[j] <= IMG_RST;
					mach_sync2_reg[j] <= IMG_RST;
					mach_in_img_reg[j] <= IMG_RST;
					mach_res_reg[j] <= IMG_RST;
					mach_out_img_reg[j] <= IMG_RST;
					l2_mach_latch_reg[j] <= IMG_RST;
				end else begin
					mach_sync1_reg[j] <= mach_in[8*j +: 8];
					mach_sync2_reg[j] <= mach_sync1_reg[j];
					if (xchg_pulse) begin
						mach_in_img_reg[j] <= mach_sync2_reg[j]; // R10
						mach_out_img_reg[j] <= mach_res_reg[j]; // R14
					end
					if (res_we && res_to_mach && res_addr == HOST_AW'(j)) begin
						mach_res_reg[j] <= res_data;
					end
					if (l2_restart || l2_cycle_start) begin
						l2_mach_latch_reg[j] <= mach_in_img_reg[j]; // R11 R12
					end
				end
			end
			assign mach_out[8*j +: 8] = mach_out_img_reg[j]; // R14
		end
	endgenerate

	// ----------------------------------------
	// Rung input view
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rd_host_in <= IMG_RST;
			rd_mach_in <= IMG_RST;
		end else if (phase_reg == PSS_PH_L2) begin
			rd_host_in <= l2_host_latch_reg[rd_addr]; // R12
			rd_mach_in <= rd_mach(l2_mach_latch_reg, rd_addr);
		end else begin
			rd_host_in <= host_in_img_reg[rd_addr]; // R9
			rd_mach_in <= rd_mach(mach_in_img_reg, rd_addr); // R10
		end
	end

	// ----------------------------------------
	// Timers, counters and presets
	// ----------------------------------------
	// tc_sel: 0 timer, 1 timer preset, 2 counter, 3 counter preset
	always_ff @(posedge core_clk) begin
		if (tc_we) begin
			tc_mem_reg[tc_sel][tc_addr] <= tc_wdata; // R17 R18
		end
		tc_rdata <= tc_mem_reg[tc_sel][tc_addr];
	end

	// ----------------------------------------
	// Diagnostics
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			diag_data <= IMG_RST;
		end else if (diag_sel == PSS_IMG_HOST_IN) begin
			diag_data <= host_in_img_reg[diag_addr]; // R15
		end else if (diag_sel == PSS_IMG_HOST_OUT) begin
			diag_data <= host_out_img_reg[diag_addr];
		end else if (diag_sel == PSS_IMG_MACH_IN) begin
			diag_data <= rd_mach(mach_in_img_reg, diag_addr);
		end else begin
			diag_data <= rd_mach(mach_out_img_reg, diag_addr);
		end
	end
endmodule : pss_scheduler

// ### sim/pss_monitor.sv
`timescale 1ns/1ns
module pss_monitor #(
	parameter int SLOT_CYCLES = 400,
	parameter int MS_CYCLES = 50,
	parameter int L1_RUNGS = 8,
	parameter int L2_RUNGS = 16,
	parameter int RUNG_AW = 8,
	parameter int PART_AW = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [PART_AW-1:0] l2_parts,
	input wire logic host_win,
	input wire logic xchg_win,
	input wire logic rung_go,
	input wire logic rung_lvl2,
	input wire logic [RUNG_AW-1:0] rung_idx,
	input wire logic rung_done,
	input wire logic l2_cycle_start,
	input wire logic [8*pss_pkg::MACH_BYTES-1:0] mach_out,
	input wire logic [PART_AW-1:0] l2_part
);
	import pss_pkg::*;
	int cnt_reg, n, len;
	logic [PART_AW-1:0] mid_reg;
	logic have_reg;
	// Zero partitions behaves as one
	assign n = (l2_parts == '0) ? 1 : int'(l2_parts);
	assign len = (L2_RUNGS + n - 1) / n;
	always_ff @(posedge core_clk) cnt_reg <= (!rstn || cnt_reg == SLOT_CYCLES - 1) ? 0 : cnt_reg + 1;
	// Sample at 2 ms into the slot, clear of any edge update
	always_ff @(posedge core_clk) if (cnt_reg == 2 * MS_CYCLES) mid_reg <= l2_part;
	always_ff @(posedge core_clk) begin
		if (!rstn) have_reg <= 1'b0;
		else if (cnt_reg == 2 * MS_CYCLES) have_reg <= 1'b1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_HOST_WIN: assert property (host_win == (cnt_reg < MS_CYCLES))
		else $error("host window misplaced");
	AST_XCHG_WIN: assert property (xchg_win == (cnt_reg >= 4 * MS_CYCLES && cnt_reg < 5 * MS_CYCLES))
		else $error("exchange window misplaced");
	AST_GO_HALT: assert property (host_win || xchg_win |-> !rung_go)
		else $error("evaluation inside a window");
	AST_L1_START: assert property (cnt_reg == MS_CYCLES |-> rung_go && !rung_lvl2 && rung_idx == '0)
		else $error("level one did not restart at rung zero");
	AST_RUNG_STEP: assert property (rung_go && rung_done && !rung_lvl2 && rung_idx < L1_RUNGS - 1
		&& cnt_reg != 4 * MS_CYCLES - 1 && cnt_reg != SLOT_CYCLES - 1 |=> rung_idx == $past(rung_idx) + 1'b1)
		else $error("rung order broken");
	AST_PART_NEXT: assert property (have_reg && cnt_reg == 2 * MS_CYCLES |->
		int'(l2_part) == (int'(mid_reg) + 1) % n)
		else $error("partition did not advance");
	AST_L2_PULSE: assert property (l2_cycle_start && have_reg |-> cnt_reg == 0)
		else $error("level two start pulse misplaced");
	AST_OUT_HOLD: assert property ($changed(mach_out) |-> cnt_reg inside {[4 * MS_CYCLES:4 * MS_CYCLES + 1]})
		else $error("machine outputs moved outside exchange");
	AST_PART_RANGE: assert property (rung_go && rung_lvl2 |-> int'(rung_idx) >= int'(l2_part) * len
		&& int'(rung_idx) < (int'(l2_part) + 1) * len)
		else $error("rung outside its partition");
	AST_L1_FIRST: assert property (cnt_reg >= MS_CYCLES && cnt_reg < MS_CYCLES + L1_RUNGS |-> !rung_lvl2)
		else $error("level two before level one");
	cover property (l2_cycle_start && have_reg);
	cover property (rung_go && rung_lvl2);
	cover property (rung_go && rung_done);
endmodule : pss_monitor
bind pss_scheduler pss_monitor #(.SLOT_CYCLES(SLOT_CYCLES), .MS_CYCLES(MS_CYCLES), .L1_RUNGS(L1_RUNGS),
	.L2_RUNGS(L2_RUNGS), .RUNG_AW(RUNG_AW), .PART_AW(PART_AW)) u_pss_monitor (.core_clk, .rstn, .l2_parts,
	.host_win, .xchg_win, .rung_go, .rung_lvl2, .rung_idx, .rung_done, .l2_cycle_start, .mach_out, .l2_part);

// ### sim/pss_far_model.sv
`timescale 1ns/1ns
module pss_far_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic host_win,
	input wire logic [7:0] pat,
	output logic host_we,
	output logic [pss_pkg::HOST_AW-1:0] host_addr,
	output logic [7:0] host_wdata,
	output logic [8*pss_pkg::MACH_BYTES-1:0] mach_in
);
	import pss_pkg::*;
	initial host_we = 1'b0;
	initial host_addr = 8'h00;
	initial host_wdata = 8'h00;
	// Host writes only inside its window
	always @(negedge core_clk) begin
		host_we <= host_win & rstn;
		host_addr <= host_we ? host_addr + 8'h01 : 8'h00;
		host_wdata <= pat ^ (host_we ? host_addr + 8'h01 : 8'h00);
	end
	always_comb for (int j = 0; j < MACH_BYTES; j++) mach_in[8*j+:8] = pat + 8'(j);
endmodule : pss_far_model

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import pss_pkg::*;
	localparam int MS = 50;
	localparam int SLOT = 400;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] l2_parts = 4'h2;
	logic host_win, host_we, xchg_win, rung_go, rung_lvl2, l2_cycle_start;
	logic [7:0] host_addr, host_wdata, host_rdata, rd_host_in, rd_mach_in, diag_data, rung_idx;
	logic [7:0] pat = 8'h00;
	logic [7:0] rd_addr = 8'h00;
	logic [7:0] res_addr = 8'h00;
	logic [7:0] res_data = 8'h00;
	logic [7:0] diag_addr = 8'h00;
	logic [1:0] diag_sel = 2'b00;
	logic [1:0] tc_sel = 2'b00;
	logic res_we = 1'b0;
	logic res_to_mach = 1'b0;
	logic tc_we = 1'b0;
	logic rung_done = 1'b0;
	logic [6:0] tc_addr = 7'h00;
	logic [15:0] tc_wdata = 16'h0000;
	logic [15:0] tc_rdata;
	logic [1023:0] mach_in, mach_out;
	logic [3:0] l2_part;
	logic [31:0] rnd = 32'h6291;
	logic [7:0] hist [0:7];
	logic [15:0] wv [0:7];
	int pos = 0;
	int num_errors = 0;
	int num_checks = 0;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [7:0] img(input int s, input logic [7:0] a, input logic mach);
		if (s < 0) return 8'h00;
		return mach ? hist[s] + a : hist[s] ^ a;
	endfunction : img
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(negedge core_clk);
	endtask : step
	task automatic at(input int c);
		while (pos != c) @(negedge core_clk);
	endtask : at
	task final_report;
		if (num_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	initial forever #2 core_clk = ~core_clk;
	always @(posedge core_clk) pos <= (!rstn || pos == SLOT - 1) ? 0 : pos + 1;
	// Early done pulses only outside level two, so the latch read below stays in level two
	always @(negedge core_clk) begin
		rnd <= lfsr(rnd);
		rung_done <= rnd[3] & ~rung_lvl2;
	end
	pss_scheduler #(.SLOT_CYCLES(SLOT), .MS_CYCLES(MS), .STEP_CYCLES(4), .L1_RUNGS(8), .L2_RUNGS(16))
		u_pss_scheduler (.core_clk, .rstn, .l2_parts, .host_win, .host_we, .host_addr, .host_wdata, .host_rdata,
		.mach_in, .mach_out, .xchg_win, .rung_go, .rung_lvl2, .rung_idx, .rung_done, .l2_cycle_start, .rd_addr,
		.rd_host_in, .rd_mach_in, .res_we, .res_to_mach, .res_addr, .res_data, .tc_we, .tc_sel, .tc_addr,
		.tc_wdata, .tc_rdata, .diag_sel, .diag_addr, .diag_data, .l2_part);
	pss_far_model u_pss_far_model (.core_clk, .rstn, .host_win, .pat, .host_we, .host_addr, .host_wdata, .mach_in);
	initial begin
		logic [7:0] a;
		logic [7:0] d;
		int w;
		step(20);
		rstn <= 1'b1;
		tc_we = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wv[i] = rnd[15:0] ^ 16'(i);
			tc_sel = 2'(i % 4);
			tc_addr = i < 4 ? 7'h00 : 7'h7F;
			tc_wdata = wv[i];
			step(1);
		end
		tc_we = 1'b0;
		for (int i = 0; i < 8; i++) begin
			tc_sel = 2'(i % 4);
			tc_addr = i < 4 ? 7'h00 : 7'h7F;
			step(1);
			chk("tc_rdata", tc_rdata, wv[i]);
		end
		for (int s = 0; s < 6; s++) begin
			hist[s] = pat;
			a = {3'b000, rnd[4:0]};
			d = rnd[15:8];
			at(MS + 1);
			rd_addr = a;
			res_we = 1'b1;
			res_to_mach = 1'b1;
			res_addr = a;
			res_data = d;
			step(1);
			chk("rd_host_in l1", rd_host_in, img(s - 1, a, 1'b0));
			chk("rd_mach_in l1", rd_mach_in, img(s - 1, a, 1'b1));
			res_to_mach = 1'b0;
			res_addr = 8'hFF;
			res_data = ~d;
			step(1);
			res_addr = 8'h00;
			res_data = d ^ 8'h5A;
			step(1);
			res_we = 1'b0;
			w = 0;
			while (!(rung_go === 1'b1 && rung_lvl2 === 1'b1) && w < 140) begin
				step(1);
				w++;
			end
			step(1);
			chk("rung_lvl2", 16'(rung_lvl2), 16'h0001);
			chk("rd_host_in l2", rd_host_in, img(s - s % 2 - 1, a, 1'b0));
			chk("rd_mach_in l2", rd_mach_in, img(s - s % 2 - 1, a, 1'b1));
			at(5 * MS + 2);
			chk("mach_out", mach_out[8*a+:8], d);
			chk("host_rdata", host_rdata, d ^ 8'h5A);
			for (int k = 0; k < 4; k++) begin
				diag_sel = 2'(k);
				diag_addr = k == 1 ? 8'hFF : a;
				step(1);
				chk("diag_data", diag_data, 8'(k == 0 ? hist[s] ^ a : k == 1 ? ~d : k == 2 ? hist[s] + a : d));
			end
			at(6 * MS);
			pat = rnd[7:0];
			at(SLOT - 1);
			step(1);
		end
		final_report();
	end
	initial begin
		repeat (20 + 7 * SLOT) @(posedge core_clk);
		num_errors++;
		final_report();
	end
endmodule : tb_top
